/* File: rtl/mss_defs.svh */
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH
// How it works
// - Decrement to accumulator, skip on zero result
// - Decrement-to-accumulator leaves memory byte untouched
// - Byte fill writes FFH, flags untouched
// - Bit fill sets only the chosen bit
// - Skip discards prefetch: two cycles, else one
// - Increment memory in place, skip on zero
// - Increment to accumulator, memory kept, skip zero
// - Skip when chosen bit is one
// - Subtract memory into accumulator, four flags
// - Subtract memory, result into memory, flags
// - Subtract immediate into accumulator, four flags
// - Swap nibbles of memory byte in place
// - Swapped byte into accumulator, memory kept
// - Skip when whole byte is zero
// - Copy byte to accumulator, skip zero
// - Skip when chosen bit is zero
// - Table read: low to memory, high aside

// ==========================================
// Register byte offsets
`define MSS_OFF_INSTR 8'h00
`define MSS_OFF_STATUS 8'h04
`define MSS_OFF_ACC 8'h08
`define MSS_OFF_TPTR 8'h0c
`define MSS_OFF_THIGH 8'h10
`define MSS_OFF_PAGE 8'h14
`define MSS_OFF_WIN 8'h18
`define MSS_OFF_MDATA 8'h1c
`define MSS_OFF_FLAGS 8'h20

// ==========================================
// Field positions
`define MSS_OP_LSB 0
`define MSS_OP_MSB 3
`define MSS_BIT_LSB 4
`define MSS_BIT_MSB 6
`define MSS_MA_LSB 8
`define MSS_MA_MSB 15
`define MSS_IMM_LSB 16
`define MSS_IMM_MSB 23
`define MSS_FLG_C 0
`define MSS_FLG_AC 1
`define MSS_FLG_Z 2
`define MSS_FLG_OV 3
`define MSS_FLG_MSB 5
`define MSS_ST_SKIP 0
`define MSS_ST_ILL 1
`define MSS_ST_CYC_LSB 4
`define MSS_ST_CYC_MSB 5

// ==========================================
// Values
`define MSS_FILL_BYTE 8'hff
`define MSS_ACC_RST 8'h00
`define MSS_FLAGS_RST 6'h00
`define MSS_CYC_PLAIN 2'h1
`define MSS_CYC_SKIP 2'h2
`endif

/* File: rtl/mss_pkg.sv */
package mss_pkg;
  // ==========================================
  // Instruction codes
  typedef enum logic [3:0] {
    mss_op_decrement_skip_to_working_reg = 4'h0,
    mss_op_fill_all_ones = 4'h1,
    mss_op_fill_bit = 4'h2,
    mss_op_increment_skip_on_wrap = 4'h3,
    mss_op_increment_skip_to_working_reg = 4'h4,
    mss_op_skip_if_bit_nonzero = 4'h5,
    mss_op_difference_into_working_reg = 4'h6,
    mss_op_difference_into_memory = 4'h7,
    mss_op_difference_immediate = 4'h8,
    mss_op_nibble_exchange = 4'h9,
    mss_op_nibble_exchange_to_working_reg = 4'ha,
    mss_op_skip_when_zero = 4'hb,
    mss_op_copy_skip_when_zero = 4'hc,
    mss_op_skip_if_bit_zero = 4'hd,
    mss_op_current_page_table_read = 4'he
  } mss_op_t;

  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {
    mss_st_idle = 3'h1,
    mss_st_exec = 3'h2,
    mss_st_dummy = 3'h4
  } mss_state_t;
endpackage

/* File: rtl/mss_alu.sv */
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_alu (
  input mss_pkg::mss_op_t op,
  input logic [7:0] acc,
  input logic [7:0] mem,
  input logic [7:0] imm,
  input logic [2:0] bsel,
  input logic [7:0] tbl_lo,
  output logic [7:0] res,
  output logic wr_acc,
  output logic wr_mem,
  output logic skip,
  output logic upd_flags,
  output logic legal,
  output logic ov,
  output logic z,
  output logic ac,
  output logic c
);
  logic [7:0] sub_b;
  logic [8:0] diff9;
  logic [4:0] half5;

  // Bit select decode, shared by bit fill and both bit tests
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // ==========================================
  // Subtract as add of complement plus one
  assign sub_b = (op == mss_pkg::mss_op_difference_immediate) ? imm : mem;
  assign diff9 = {1'b0, acc} + {1'b0, ~sub_b} + 9'h001;
  assign half5 = {1'b0, acc[3:0]} + {1'b0, ~sub_b[3:0]} + 5'h01;
  // Carry set means no borrow
  assign c = diff9[8];
  assign ac = half5[4];
  assign z = (diff9[7:0] == 8'h00);
  assign ov = (acc[7] ^ sub_b[7]) & (acc[7] ^ diff9[7]);

  // ==========================================
  // Result, destination and skip per opcode
  always_comb
  begin
    res = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    skip = 1'b0;
    upd_flags = 1'b0;
    legal = 1'b1;
    case (op)
      mss_pkg::mss_op_decrement_skip_to_working_reg:
      begin
        res = mem - 8'h01;
        wr_acc = 1'b1;
        skip = (res == 8'h00);
      end
      mss_pkg::mss_op_fill_all_ones:
      begin
        res = `MSS_FILL_BYTE;
        wr_mem = 1'b1;
      end
      mss_pkg::mss_op_fill_bit:
      begin
        res = mem | bit_mask(bsel);
        wr_mem = 1'b1;
      end
      mss_pkg::mss_op_increment_skip_on_wrap:
      begin
        res = mem + 8'h01;
        wr_mem = 1'b1;
        skip = (res == 8'h00);
      end
      mss_pkg::mss_op_increment_skip_to_working_reg:
      begin
        res = mem + 8'h01;
        wr_acc = 1'b1;
        skip = (res == 8'h00);
      end
      mss_pkg::mss_op_skip_if_bit_nonzero:
        skip = |(mem & bit_mask(bsel));
      mss_pkg::mss_op_difference_into_working_reg:
      begin
        res = diff9[7:0];
        wr_acc = 1'b1;
        upd_flags = 1'b1;
      end
      mss_pkg::mss_op_difference_into_memory:
      begin
        res = diff9[7:0];
        wr_mem = 1'b1;
        upd_flags = 1'b1;
      end
      mss_pkg::mss_op_difference_immediate:
      begin
        res = diff9[7:0];
        wr_acc = 1'b1;
        upd_flags = 1'b1;
      end
      mss_pkg::mss_op_nibble_exchange:
      begin
        res = {mem[3:0], mem[7:4]};
        wr_mem = 1'b1;
      end
      mss_pkg::mss_op_nibble_exchange_to_working_reg:
      begin
        res = {mem[3:0], mem[7:4]};
        wr_acc = 1'b1;
      end
      mss_pkg::mss_op_skip_when_zero:
        skip = (mem == 8'h00);
      mss_pkg::mss_op_copy_skip_when_zero:
      begin
        res = mem;
        wr_acc = 1'b1;
        skip = (mem == 8'h00);
      end
      mss_pkg::mss_op_skip_if_bit_zero:
        skip = ~|(mem & bit_mask(bsel));
      mss_pkg::mss_op_current_page_table_read:
      begin
        res = tbl_lo;
        wr_mem = 1'b1;
      end
      default:
        legal = 1'b0;
    endcase
  end
endmodule

/* File: rtl/mss_exec.sv */
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_exec #(
  parameter int DM_DEPTH = 160,
  parameter int PM_AW = 12,
  parameter int PM_W = 15
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PM_AW-1:0] pm_addr,
  input logic [PM_W-1:0] pm_data,
  output logic discard
);
  localparam int PG_W = PM_AW - 8;
  localparam int TH_W = PM_W - 8;

  // ==========================================
  // Whole state of the block
  typedef struct packed {
    mss_pkg::mss_state_t st;
    mss_pkg::mss_op_t op;
    logic [2:0] bsel;
    logic [7:0] maddr;
    logic [7:0] imm;
    logic [7:0] acc;
    logic [`MSS_FLG_MSB:0] flags;
    logic [7:0] tptr;
    logic [TH_W-1:0] thigh;
    logic [PG_W-1:0] page;
    logic [7:0] win;
    logic skip;
    logic illegal;
    logic [1:0] cycles;
    logic [PM_AW-1:0] pm_addr;
    logic discard;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [DM_DEPTH-1:0][7:0] dm;
  } mss_regs_t;

  mss_regs_t s_r;
  mss_regs_t s_nxt;
  logic [7:0] mem_rd;
  logic in_rng;
  logic [7:0] alu_res;
  logic alu_wr_acc;
  logic alu_wr_mem;
  logic alu_skip;
  logic alu_upd;
  logic alu_legal;
  logic alu_ov;
  logic alu_z;
  logic alu_ac;
  logic alu_c;
  logic hs;

  // ==========================================
  // Helpers
  // Out-of-range addresses read zero and swallow writes
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = ({24'h000000, a} < DM_DEPTH);
  endfunction

  function automatic logic [7:0] dm_read(
    input logic [DM_DEPTH-1:0][7:0] m,
    input logic [7:0] a
  );
    dm_read = 8'h00;
    if (addr_ok(a))
    begin
      dm_read = m[a];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `MSS_OFF_INSTR, `MSS_OFF_STATUS, `MSS_OFF_ACC,
      `MSS_OFF_TPTR, `MSS_OFF_THIGH, `MSS_OFF_PAGE,
      `MSS_OFF_WIN, `MSS_OFF_MDATA, `MSS_OFF_FLAGS:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input mss_regs_t r, input logic [7:0] a);
    rd_word = 32'h00000000;
    case (a)
      `MSS_OFF_INSTR:
      begin
        rd_word[`MSS_OP_MSB:`MSS_OP_LSB] = r.op;
        rd_word[`MSS_BIT_MSB:`MSS_BIT_LSB] = r.bsel;
        rd_word[`MSS_MA_MSB:`MSS_MA_LSB] = r.maddr;
        rd_word[`MSS_IMM_MSB:`MSS_IMM_LSB] = r.imm;
      end
      `MSS_OFF_STATUS:
      begin
        rd_word[`MSS_ST_SKIP] = r.skip;
        rd_word[`MSS_ST_ILL] = r.illegal;
        rd_word[`MSS_ST_CYC_MSB:`MSS_ST_CYC_LSB] = r.cycles;
      end
      `MSS_OFF_ACC: rd_word[7:0] = r.acc;
      `MSS_OFF_TPTR: rd_word[7:0] = r.tptr;
      `MSS_OFF_THIGH: rd_word[TH_W-1:0] = r.thigh;
      `MSS_OFF_PAGE: rd_word[PG_W-1:0] = r.page;
      `MSS_OFF_WIN: rd_word[7:0] = r.win;
      `MSS_OFF_MDATA: rd_word[7:0] = dm_read(r.dm, r.win);
      `MSS_OFF_FLAGS: rd_word[`MSS_FLG_MSB:0] = r.flags;
      default: rd_word = 32'h00000000;
    endcase
  endfunction

  assign mem_rd = dm_read(s_r.dm, s_r.maddr);
  assign in_rng = addr_ok(s_r.maddr);
  assign hs = psel & penable & s_r.pready;

  // ==========================================
  // Datapath
  mss_alu u_alu (
    .op(s_r.op),
    .acc(s_r.acc),
    .mem(mem_rd),
    .imm(s_r.imm),
    .bsel(s_r.bsel),
    .tbl_lo(pm_data[7:0]),
    .res(alu_res),
    .wr_acc(alu_wr_acc),
    .wr_mem(alu_wr_mem),
    .skip(alu_skip),
    .upd_flags(alu_upd),
    .legal(alu_legal),
    .ov(alu_ov),
    .z(alu_z),
    .ac(alu_ac),
    .c(alu_c)
  );

  // ==========================================
  // Next state: bus slave and sequencer
  // Bus only answers when idle, so software and execution never
  // write the same storage in one cycle.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    // Answer one cycle after setup, stalled while an op runs
    if (psel && !s_r.pready && (s_r.st == mss_pkg::mss_st_idle))
    begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~mapped(paddr);
      s_nxt.prdata = pwrite ? 32'h00000000 : rd_word(s_r, paddr);
    end
    if (hs && pwrite && mapped(paddr))
    begin
      case (paddr)
        `MSS_OFF_INSTR:
        begin
          s_nxt.op = mss_pkg::mss_op_t'(pwdata[`MSS_OP_MSB:`MSS_OP_LSB]);
          s_nxt.bsel = pwdata[`MSS_BIT_MSB:`MSS_BIT_LSB];
          s_nxt.maddr = pwdata[`MSS_MA_MSB:`MSS_MA_LSB];
          s_nxt.imm = pwdata[`MSS_IMM_MSB:`MSS_IMM_LSB];
          // Table word is addressed ahead so it is valid in the exec cycle
          s_nxt.pm_addr = {s_r.page, s_r.tptr};
          s_nxt.st = mss_pkg::mss_st_exec;
        end
        `MSS_OFF_ACC: s_nxt.acc = pwdata[7:0];
        `MSS_OFF_TPTR: s_nxt.tptr = pwdata[7:0];
        `MSS_OFF_PAGE: s_nxt.page = pwdata[PG_W-1:0];
        `MSS_OFF_WIN: s_nxt.win = pwdata[7:0];
        `MSS_OFF_FLAGS: s_nxt.flags = pwdata[`MSS_FLG_MSB:0];
        `MSS_OFF_MDATA:
        begin
          if (addr_ok(s_r.win))
          begin
            s_nxt.dm[s_r.win] = pwdata[7:0];
          end
        end
        default: s_nxt.prdata = s_r.prdata;
      endcase
    end
    // Sequencer
    case (s_r.st)
      mss_pkg::mss_st_idle:
        s_nxt.discard = 1'b0;
      mss_pkg::mss_st_exec:
      begin
        s_nxt.illegal = ~alu_legal;
        s_nxt.skip = alu_skip;
        if (alu_wr_acc)
        begin
          s_nxt.acc = alu_res;
        end
        if (alu_wr_mem && in_rng)
        begin
          s_nxt.dm[s_r.maddr] = alu_res;
        end
        if (alu_upd)
        begin
          s_nxt.flags[`MSS_FLG_OV] = alu_ov;
          s_nxt.flags[`MSS_FLG_Z] = alu_z;
          s_nxt.flags[`MSS_FLG_AC] = alu_ac;
          s_nxt.flags[`MSS_FLG_C] = alu_c;
        end
        if (s_r.op == mss_pkg::mss_op_current_page_table_read)
        begin
          s_nxt.thigh = pm_data[PM_W-1:8];
        end
        // Prefetched word is dropped with one dummy cycle
        if (alu_skip)
        begin
          s_nxt.cycles = `MSS_CYC_SKIP;
          s_nxt.discard = 1'b1;
          s_nxt.st = mss_pkg::mss_st_dummy;
        end
        else
        begin
          s_nxt.cycles = `MSS_CYC_PLAIN;
          s_nxt.st = mss_pkg::mss_st_idle;
        end
      end
      mss_pkg::mss_st_dummy:
      begin
        s_nxt.discard = 1'b0;
        s_nxt.st = mss_pkg::mss_st_idle;
      end
      default:
      begin
        s_nxt.discard = 1'b0;
        s_nxt.st = mss_pkg::mss_st_idle;
      end
    endcase
  end

  // ==========================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.st <= mss_pkg::mss_st_idle;
      s_r.acc <= `MSS_ACC_RST;
      s_r.flags <= `MSS_FLAGS_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign pm_addr = s_r.pm_addr;
  assign discard = s_r.discard;

  // ==========================================
  // Checks
  property p_dec_acc;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec &&
       s_r.op == mss_pkg::mss_op_decrement_skip_to_working_reg)
      |=> (s_r.acc == 8'($past(mem_rd) - 8'h01)) &&
          (s_r.skip == ($past(mem_rd) == 8'h01));
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement result wrong");

  property p_dec_keep;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec &&
       s_r.op == mss_pkg::mss_op_decrement_skip_to_working_reg)
      |=> (s_r.dm == $past(s_r.dm));
  endproperty
  a_dec_keep: assert property (p_dec_keep) else $error("memory changed");

  property p_fill;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec && in_rng &&
       s_r.op == mss_pkg::mss_op_fill_all_ones)
      |=> (mem_rd == `MSS_FILL_BYTE) && $stable(s_r.flags);
  endproperty
  a_fill: assert property (p_fill) else $error("byte fill wrong");

  property p_fill_bit;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec && in_rng &&
       s_r.op == mss_pkg::mss_op_fill_bit)
      |=> (mem_rd[s_r.bsel] == 1'b1) &&
          ((mem_rd ^ $past(mem_rd)) == (8'h01 << s_r.bsel) ||
           mem_rd == $past(mem_rd));
  endproperty
  a_fill_bit: assert property (p_fill_bit) else $error("bit fill wrong");

  property p_skip_len;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec && alu_skip)
      |=> (s_r.discard && s_r.st == mss_pkg::mss_st_dummy)
          ##1 (!s_r.discard && s_r.st == mss_pkg::mss_st_idle);
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip not two cycles");

  property p_plain_len;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec && !alu_skip)
      |=> (s_r.st == mss_pkg::mss_st_idle) && !s_r.discard;
  endproperty
  a_plain_len: assert property (p_plain_len) else $error("plain op not one cycle");

  property p_inc_mem;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec && in_rng &&
       s_r.op == mss_pkg::mss_op_increment_skip_on_wrap)
      |=> (mem_rd == 8'($past(mem_rd) + 8'h01)) &&
          (s_r.skip == ($past(mem_rd) == `MSS_FILL_BYTE));
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment in place wrong");

  property p_bit_one_test;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec &&
       s_r.op == mss_pkg::mss_op_skip_if_bit_nonzero)
      |-> (alu_skip == mem_rd[s_r.bsel]);
  endproperty
  a_bit_one_test: assert property (p_bit_one_test) else $error("bit set test wrong");

  property p_sub_carry;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec &&
       s_r.op == mss_pkg::mss_op_difference_into_working_reg)
      |=> (s_r.flags[`MSS_FLG_C] == ($past(s_r.acc) >= $past(mem_rd))) &&
          (s_r.flags[`MSS_FLG_Z] == ($past(s_r.acc) == $past(mem_rd)));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract flags wrong");

  property p_swap;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec && in_rng &&
       s_r.op == mss_pkg::mss_op_nibble_exchange)
      |=> (mem_rd == {$past(mem_rd[3:0]), $past(mem_rd[7:4])});
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_zero_test;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec &&
       s_r.op == mss_pkg::mss_op_skip_when_zero)
      |-> (alu_skip == (mem_rd == 8'h00)) ##1 $stable(s_r.acc);
  endproperty
  a_zero_test: assert property (p_zero_test) else $error("zero test wrong");

  property p_table;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec &&
       s_r.op == mss_pkg::mss_op_current_page_table_read)
      |=> (s_r.thigh == $past(pm_data[PM_W-1:8]));
  endproperty
  a_table: assert property (p_table) else $error("table high byte wrong");

  property p_flags_kept;
    @(posedge pclk) disable iff (!presetn)
      (s_r.st == mss_pkg::mss_st_exec && !alu_upd)
      |=> $stable(s_r.flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");
endmodule

/* File: verification/mss_exec_tb.sv */
`timescale 1ns/1ps
`include "mss_defs.svh"
module mcu_skip_sub_swap_table_exec_tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] pm_addr;
  logic [14:0] pm_data;
  logic discard;
  int mismatches;
  int check_count;
  int disc_n = 0;
  int d0;
  logic [7:0] ma;

  // ==========================================
  // Clock and device
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  mss_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data), .discard(discard));

  // Count dummy cycles; a skip must show exactly one
  always @(posedge pclk)
    if (discard === 1'b1) disc_n <= disc_n + 1;

  // ==========================================
  // Checking and closing
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================
  // APB master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    logic ok;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    ok = 1'b0;
    // Bounded wait: an instruction in flight stalls the bus
    while (!ok && n < 20)
    begin
      @(posedge pclk);
      n++;
      ok = (pready === 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic ee = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask

  // Two's-complement subtract: {ov, z, ac, c, result}; carry means no borrow
  function automatic logic [11:0] sub8(input logic [7:0] x, input logic [7:0] y);
    logic [7:0] r;
    r = x + ~y + 8'h01;
    return {(x[7] != y[7]) && (r[7] != x[7]), r == 8'h00, x[3:0] >= y[3:0], x >= y, r};
  endfunction

  // ==========================================
  // One instruction: preload, launch, then compare every visible effect
  task automatic run(input mss_pkg::mss_op_t op, input logic [2:0] b, input logic [7:0] m,
                     input logic [7:0] a, input logic [7:0] imm);
    logic [7:0] em, ea, dec, inc, sw;
    logic [5:0] f, ef;
    logic sk;
    logic [11:0] s;
    int c0;
    // Alternate flag patterns so a stuck flag bit shows up
    f = ma[0] ? 6'h35 : 6'h0a;
    em = m;
    ea = a;
    ef = f;
    sk = 1'b0;
    dec = m - 8'h01;
    inc = m + 8'h01;
    sw = {m[3:0], m[7:4]};
    s = sub8(a, (op == mss_pkg::mss_op_difference_immediate) ? imm : m);
    case (op)
      mss_pkg::mss_op_decrement_skip_to_working_reg: {ea, sk} = {dec, dec == 8'h00};
      mss_pkg::mss_op_fill_all_ones: em = `MSS_FILL_BYTE;
      mss_pkg::mss_op_fill_bit: em = m | (8'h01 << b);
      mss_pkg::mss_op_increment_skip_on_wrap: {em, sk} = {inc, inc == 8'h00};
      mss_pkg::mss_op_increment_skip_to_working_reg: {ea, sk} = {inc, inc == 8'h00};
      mss_pkg::mss_op_skip_if_bit_nonzero: sk = m[b];
      mss_pkg::mss_op_difference_into_working_reg: {ef[3:0], ea} = s;
      mss_pkg::mss_op_difference_into_memory: {ef[3:0], em} = s;
      mss_pkg::mss_op_difference_immediate: {ef[3:0], ea} = s;
      mss_pkg::mss_op_nibble_exchange: em = sw;
      mss_pkg::mss_op_nibble_exchange_to_working_reg: ea = sw;
      mss_pkg::mss_op_skip_when_zero: sk = (m == 8'h00);
      mss_pkg::mss_op_copy_skip_when_zero: {ea, sk} = {m, m == 8'h00};
      mss_pkg::mss_op_skip_if_bit_zero: sk = ~m[b];
      default: sk = 1'b0;
    endcase
    wr(`MSS_OFF_WIN, {24'h0, ma});
    wr(`MSS_OFF_MDATA, {24'h0, m});
    wr(`MSS_OFF_ACC, {24'h0, a});
    wr(`MSS_OFF_FLAGS, {26'h0, f});
    c0 = disc_n;
    wr(`MSS_OFF_INSTR, {8'h00, imm, ma, 1'b0, b, op});
    rd_chk(`MSS_OFF_MDATA, {24'h0, em});
    rd_chk(`MSS_OFF_ACC, {24'h0, ea});
    rd_chk(`MSS_OFF_FLAGS, {26'h0, ef});
    rd_chk(`MSS_OFF_STATUS, {26'h0, sk ? `MSS_CYC_SKIP : `MSS_CYC_PLAIN, 3'h0, sk});
    chk(disc_n - c0, {31'h0, sk});
    ma = ma + 8'h01;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pm_data = 15'h0;
    presetn = 1'b0;
    mismatches = 0;
    check_count = 0;
    ma = 8'h10;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state, unmapped address, window past the end of data memory
    rd_chk(`MSS_OFF_ACC, 32'h0);
    rd_chk(`MSS_OFF_FLAGS, 32'h0);
    rd_chk(8'h24, 32'h0, 1'b1);
    wr(`MSS_OFF_WIN, 32'ha0);
    wr(`MSS_OFF_MDATA, 32'h55);
    rd_chk(`MSS_OFF_MDATA, 32'h0);
    // Boundary values around zero and wrap for every opcode except table read
    run(mss_pkg::mss_op_decrement_skip_to_working_reg, 3'h0, 8'h01, 8'h77, 8'h00);
    run(mss_pkg::mss_op_decrement_skip_to_working_reg, 3'h0, 8'h00, 8'h77, 8'h00);
    run(mss_pkg::mss_op_fill_all_ones, 3'h0, 8'h12, 8'h00, 8'h00);
    run(mss_pkg::mss_op_fill_bit, 3'h5, 8'h00, 8'h00, 8'h00);
    run(mss_pkg::mss_op_fill_bit, 3'h0, 8'haa, 8'h00, 8'h00);
    run(mss_pkg::mss_op_increment_skip_on_wrap, 3'h0, 8'hff, 8'h01, 8'h00);
    run(mss_pkg::mss_op_increment_skip_on_wrap, 3'h0, 8'h7f, 8'h01, 8'h00);
    run(mss_pkg::mss_op_increment_skip_to_working_reg, 3'h0, 8'hff, 8'h33, 8'h00);
    run(mss_pkg::mss_op_increment_skip_to_working_reg, 3'h0, 8'h10, 8'h33, 8'h00);
    run(mss_pkg::mss_op_skip_if_bit_nonzero, 3'h3, 8'h08, 8'h00, 8'h00);
    run(mss_pkg::mss_op_skip_if_bit_nonzero, 3'h3, 8'hf7, 8'h00, 8'h00);
    run(mss_pkg::mss_op_difference_into_working_reg, 3'h0, 8'h03, 8'h05, 8'h00);
    run(mss_pkg::mss_op_difference_into_working_reg, 3'h0, 8'h01, 8'h80, 8'h00);
    run(mss_pkg::mss_op_difference_into_memory, 3'h0, 8'h3c, 8'h3c, 8'h00);
    run(mss_pkg::mss_op_difference_into_memory, 3'h0, 8'h90, 8'h10, 8'h00);
    run(mss_pkg::mss_op_difference_immediate, 3'h0, 8'h00, 8'h22, 8'h2f);
    run(mss_pkg::mss_op_difference_immediate, 3'h0, 8'hee, 8'h7f, 8'hff);
    run(mss_pkg::mss_op_nibble_exchange, 3'h0, 8'ha5, 8'h0f, 8'h00);
    run(mss_pkg::mss_op_nibble_exchange_to_working_reg, 3'h0, 8'h3c, 8'h00, 8'h00);
    run(mss_pkg::mss_op_skip_when_zero, 3'h0, 8'h00, 8'h55, 8'h00);
    run(mss_pkg::mss_op_skip_when_zero, 3'h0, 8'h01, 8'h55, 8'h00);
    run(mss_pkg::mss_op_copy_skip_when_zero, 3'h0, 8'h00, 8'h99, 8'h00);
    run(mss_pkg::mss_op_copy_skip_when_zero, 3'h0, 8'h42, 8'h99, 8'h00);
    run(mss_pkg::mss_op_skip_if_bit_zero, 3'h7, 8'h7f, 8'h00, 8'h00);
    run(mss_pkg::mss_op_skip_if_bit_zero, 3'h7, 8'h80, 8'h00, 8'h00);
    // Table read from page 9, pointer 5a
    wr(`MSS_OFF_WIN, {24'h0, ma});
    wr(`MSS_OFF_MDATA, 32'h11);
    wr(`MSS_OFF_TPTR, 32'h5a);
    wr(`MSS_OFF_PAGE, 32'h9);
    wr(`MSS_OFF_FLAGS, 32'h3f);
    pm_data <= 15'h6bcd;
    d0 = disc_n;
    wr(`MSS_OFF_INSTR, {16'h0, ma, 4'h0, mss_pkg::mss_op_current_page_table_read});
    // Table address is launched at the handshake edge; look once it has settled
    @(posedge pclk);
    chk({20'h0, pm_addr}, 32'h95a);
    rd_chk(`MSS_OFF_MDATA, 32'hcd);
    rd_chk(`MSS_OFF_THIGH, 32'h6b);
    rd_chk(`MSS_OFF_FLAGS, 32'h3f);
    chk(disc_n - d0, 32'h0);
    // Unused opcode only marks itself illegal: one cycle, flags and memory kept
    wr(`MSS_OFF_INSTR, {16'h0, ma, 4'h0, 4'hf});
    rd_chk(`MSS_OFF_STATUS, 32'h12);
    rd_chk(`MSS_OFF_FLAGS, 32'h3f);
    rd_chk(`MSS_OFF_MDATA, 32'hcd);
    report_and_stop();
  end
endmodule
